/* File: rtl/cmr_map.vh */
`ifndef CMR_MAP_VH
`define CMR_MAP_VH
// APB register byte offsets
`define CMR_CFG_OFF      12'h000
`define CMR_OUTCFG_OFF   12'h004
`define CMR_STATUS_OFF   12'h008
`define CMR_VERIFY_OFF   12'h00c
`define CMR_SIG_OFF      12'h010
`define CMR_ID_OFF       12'h014
// Configuration register field positions
`define CMR_DSEL_LSB     0
`define CMR_FTYPE_LSB    2
`define CMR_LATCH_BIT    5
`define CMR_CKSEL_BIT    6
`define CMR_CEEN_BIT     7
`define CMR_CLRSEL_LSB   8
`define CMR_SETEN_BIT    10
`define CMR_PDEN_BIT     11
`define CMR_PD1EN_BIT    12
`define CMR_PD2EN_BIT    13
`define CMR_FUSE_BIT     14
`define CMR_TPDIS_BIT    15
// Data source codes
`define CMR_DSRC_XOR     2'h0
`define CMR_DSRC_PT      2'h1
`define CMR_DSRC_PIN     2'h2
// Flip-flop type codes
`define CMR_FT_D         3'h1
`define CMR_FT_T         3'h2
`define CMR_FT_JK        3'h4
// Clear source codes
`define CMR_CLR_OFF      2'h0
`define CMR_CLR_NET      2'h1
`define CMR_CLR_PT       2'h2
`define CMR_CLR_OR       2'h3
// Reset values
`define CMR_CFG_RST      32'h0000_0004
`define CMR_OUTCFG_RST   32'h0000_0000
`define CMR_PATTERN_RST  32'h0000_0000
// Arbitrary neutral identity values
`define CMR_SIG_VAL      32'h0000_5a5a
`define CMR_ID_VAL       32'h0000_1234
`endif

/* File: rtl/cmr_macrocell.v */
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "cmr_map.vh"
module cmr_macrocell (
  input  wire        CLOCK_I,
  input  wire        RESETN_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  input  wire        SHARED_CLOCK_NET_I,
  input  wire        SHARED_CLEAR_NET_I,
  input  wire        XOR_OUT_I,
  input  wire        DATA_PT_I,
  input  wire        K_PT_I,
  input  wire        CLOCK_PT_I,
  input  wire        CE_PT_I,
  input  wire        CLEAR_PT_I,
  input  wire        SET_PT_I,
  input  wire        IO_PIN_I,
  input  wire        SLEEP_PIN_ONE_I,
  input  wire        SLEEP_PIN_TWO_I,
  input  wire [3:0]  TP_PIN_I,
  input  wire        PROG_ABORT_I,
  output reg         STATE_O,
  output reg         IO_PIN_O,
  output reg         IO_PIN_OE_O,
  output reg         IO_FAST_O,
  output reg  [3:0]  TP_PIN_O,
  output reg  [3:0]  TP_PIN_OE_O,
  output reg  [3:0]  TP_PIN_IN_O,
  output reg         POWER_DOWN_O
);

////////////////////////////////////////////////////////////////////////////
// Declarations
reg  [31:0] cfg_q;
reg  [31:0] outcfg_q;
reg  [31:0] pattern_q;
reg         locked_q;
reg  [1:0]  clk_s_q;
reg  [1:0]  clr_s_q;
reg  [1:0]  pin_s_q;
reg  [1:0]  dpt_s_q;
reg  [1:0]  xor_s_q;
reg  [1:0]  kpt_s_q;
reg  [1:0]  ckpt_s_q;
reg  [1:0]  ce_s_q;
reg  [1:0]  cpt_s_q;
reg  [1:0]  spt_s_q;
reg  [1:0]  sl1_s_q;
reg  [1:0]  sl2_s_q;
reg  [1:0]  ab_s_q;
reg  [3:0]  tp_s0_q;
reg  [3:0]  tp_s1_q;
reg         clk_prev_q;
reg         state_q;
reg         state_d;
reg         data_in;
reg         clk_sel;
reg         clr_act;
reg         set_act;
reg  [31:0] rdata_d;
wire        power_down;
wire        rise;
wire        ce_ok;
wire        apb_acc;
wire        apb_wr;
wire        setup_cyc;

////////////////////////////////////////////////////////////////////////////
// Register map, byte addresses on the APB side
// 0x000 configuration
//   [1:0]   data source: 0 XOR output, 1 separate term, 2 pin
//   [4:2]   storage style: 1 D, 2 T, 4 JK, anything else SR
//   [5]     latch mode instead of edge flip-flop
//   [6]     clock source: 0 shared clock net, 1 private term
//   [7]     clock enable in use (shared clock net only)
//   [9:8]   clear source: 0 off, 1 net, 2 term, 3 net OR term
//   [10]    set term in use
//   [11]    power-down option
//   [12]    sleep pin one enabled
//   [13]    sleep pin two enabled
//   [14]    security fuse, blanks pattern readback
//   [15]    test port disabled, its pins become logic I/O
// 0x004 output configuration
//   [0]     fast slew when set, slow otherwise
//   [1]     buffer polarity, inverts the pin level
//   [2]     pin output enable
//   [7:4]   freed test-port pin levels
//   [11:8]  freed test-port pin enables
// 0x008 status, read only
//   [0] stored value [1] selected clock [2] power-down [3] locked
// 0x00c configuration pattern, reads zero once the fuse is set
// 0x010 user signature, 0x014 identification, both read only
// Anything above 0x014 answers with an error and reads zero

////////////////////////////////////////////////////////////////////////////
// Functions

// True in the setup cycle of an APB transfer; the slave answers from it
function apb_setup;
  input sel;
  input en;
  begin
    apb_setup = sel & ~en;
  end
endfunction

// Next state for the D, T and JK/SR styles; SR takes the default branch on the same two inputs
function ff_next;
  input [2:0] ftype;
  input       cur;
  input       a;
  input       b;
  begin
    case (ftype)
      `CMR_FT_D:  ff_next = a;
      `CMR_FT_T:  ff_next = cur ^ a;
      `CMR_FT_JK: ff_next = (a & ~cur) | (~b & cur);
      default:    ff_next = a | (~b & cur);
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// Input synchronisers, two flops each before any logic
// Every board input is asynchronous to CLOCK_I, so each one costs two
// cycles of latency; the trade is exactness against a metastable read
always @(posedge CLOCK_I or negedge RESETN_I) begin
  if (!RESETN_I) begin
    // Idle levels are low, so no false clock edge follows reset
    clk_s_q <= 2'h0;
    clr_s_q <= 2'h0;
    pin_s_q <= 2'h0;
    dpt_s_q <= 2'h0;
    xor_s_q <= 2'h0;
    kpt_s_q <= 2'h0;
    ckpt_s_q <= 2'h0;
    ce_s_q <= 2'h0;
    cpt_s_q <= 2'h0;
    spt_s_q <= 2'h0;
    sl1_s_q <= 2'h0;
    sl2_s_q <= 2'h0;
    ab_s_q <= 2'h0;
    tp_s0_q <= 4'h0;
    tp_s1_q <= 4'h0;
  end else begin
    // Clock and clear nets
    clk_s_q <= {clk_s_q[0], SHARED_CLOCK_NET_I};
    clr_s_q <= {clr_s_q[0], SHARED_CLEAR_NET_I};
    // Data and control terms
    pin_s_q <= {pin_s_q[0], IO_PIN_I};
    dpt_s_q <= {dpt_s_q[0], DATA_PT_I};
    xor_s_q <= {xor_s_q[0], XOR_OUT_I};
    kpt_s_q <= {kpt_s_q[0], K_PT_I};
    ckpt_s_q <= {ckpt_s_q[0], CLOCK_PT_I};
    ce_s_q <= {ce_s_q[0], CE_PT_I};
    cpt_s_q <= {cpt_s_q[0], CLEAR_PT_I};
    spt_s_q <= {spt_s_q[0], SET_PT_I};
    // Sleep pins, abort and test-port pins
    sl1_s_q <= {sl1_s_q[0], SLEEP_PIN_ONE_I};
    sl2_s_q <= {sl2_s_q[0], SLEEP_PIN_TWO_I};
    ab_s_q <= {ab_s_q[0], PROG_ABORT_I};
    tp_s0_q <= TP_PIN_I;
    tp_s1_q <= tp_s0_q;
  end
end

////////////////////////////////////////////////////////////////////////////
// Power-down: with the option bit [11] set, either enabled sleep pin high freezes the storage element and pin outputs
assign power_down = cfg_q[`CMR_PDEN_BIT] &
                    ((cfg_q[`CMR_PD1EN_BIT] & sl1_s_q[1]) |
                     (cfg_q[`CMR_PD2EN_BIT] & sl2_s_q[1]));

////////////////////////////////////////////////////////////////////////////
// Source selection for data, clock, clear and set
always @* begin
  case (cfg_q[`CMR_DSEL_LSB+1:`CMR_DSEL_LSB])
    `CMR_DSRC_PT:  data_in = dpt_s_q[1];
    `CMR_DSRC_PIN: data_in = pin_s_q[1];
    default:       data_in = xor_s_q[1];
  endcase
  clk_sel = cfg_q[`CMR_CKSEL_BIT] ? ckpt_s_q[1] : clk_s_q[1];
  case (cfg_q[`CMR_CLRSEL_LSB+1:`CMR_CLRSEL_LSB])
    `CMR_CLR_NET: clr_act = clr_s_q[1];
    `CMR_CLR_PT:  clr_act = cpt_s_q[1];
    `CMR_CLR_OR:  clr_act = clr_s_q[1] | cpt_s_q[1];
    default:      clr_act = 1'b0;
  endcase
  set_act = cfg_q[`CMR_SETEN_BIT] & spt_s_q[1];
end

// Clock enable only counts with the shared clock net chosen
assign ce_ok = cfg_q[`CMR_CKSEL_BIT] | ~cfg_q[`CMR_CEEN_BIT] |
               ce_s_q[1];
assign rise  = clk_sel & ~clk_prev_q;

// Next storage value; clear wins over set
always @* begin
  state_d = state_q;
  if (clr_act) begin
    state_d = 1'b0;
  end else if (set_act) begin
    state_d = 1'b1;
  end else if (cfg_q[`CMR_LATCH_BIT]) begin
    if (clk_sel && ce_ok) begin
      state_d = data_in;
    end
  end else if (rise && ce_ok) begin
    state_d = ff_next(cfg_q[`CMR_FTYPE_LSB+2:`CMR_FTYPE_LSB], state_q,
                      data_in, kpt_s_q[1]);
  end
end

////////////////////////////////////////////////////////////////////////////
// Storage element; frozen in power-down since pins are ignored
always @(posedge CLOCK_I or negedge RESETN_I) begin
  if (!RESETN_I) begin
    state_q    <= 1'b0;
    clk_prev_q <= 1'b0;
  end else if (!power_down) begin
    state_q    <= state_d;
    clk_prev_q <= clk_sel;
  end
end

////////////////////////////////////////////////////////////////////////////
// APB slave: zero wait states, addresses above 0x014 read zero with error
// Writes land in the access cycle; a locked device drops them
assign setup_cyc = apb_setup(PSEL_I, PENABLE_I);
assign apb_acc = PSEL_I & PENABLE_I;
assign apb_wr  = apb_acc & PWRITE_I & ~locked_q;

always @(posedge CLOCK_I or negedge RESETN_I) begin
  if (!RESETN_I) begin
    cfg_q     <= `CMR_CFG_RST;
    outcfg_q  <= `CMR_OUTCFG_RST;
    pattern_q <= `CMR_PATTERN_RST;
  end else if (apb_wr) begin
    case (PADDR_I)
      `CMR_CFG_OFF:    cfg_q <= PWDATA_I;
      `CMR_OUTCFG_OFF: outcfg_q <= PWDATA_I;
      `CMR_VERIFY_OFF: pattern_q <= PWDATA_I;
      default:         cfg_q <= cfg_q;
    endcase
  end
end

// Read mux; pattern readback blanked once the fuse is set
always @* begin
  case (PADDR_I)
    `CMR_CFG_OFF:    rdata_d = cfg_q;
    `CMR_OUTCFG_OFF: rdata_d = outcfg_q;
    `CMR_STATUS_OFF: rdata_d = {28'h0, locked_q, power_down,
                                clk_sel, state_q};
    `CMR_VERIFY_OFF: rdata_d = cfg_q[`CMR_FUSE_BIT] ? 32'h0 :
                               pattern_q;
    `CMR_SIG_OFF:    rdata_d = `CMR_SIG_VAL;
    `CMR_ID_OFF:     rdata_d = `CMR_ID_VAL;
    default:         rdata_d = 32'h0;
  endcase
end

// Answer registered from the setup cycle, so ready stands in the access
// cycle; zero wait states, and read data is zero outside that cycle
always @(posedge CLOCK_I or negedge RESETN_I) begin
  if (!RESETN_I) begin
    PRDATA_O  <= 32'h0;
    PREADY_O  <= 1'b0;
    PSLVERR_O <= 1'b0;
  end else begin
    PREADY_O  <= setup_cyc;
    PRDATA_O  <= (setup_cyc & ~PWRITE_I) ? rdata_d : 32'h0;
    PSLVERR_O <= setup_cyc & (PADDR_I > `CMR_ID_OFF);
  end
end

////////////////////////////////////////////////////////////////////////////
// Programming lock, sticky until reset
// Only reset clears it: a half-written pattern must never drive pins
always @(posedge CLOCK_I or negedge RESETN_I) begin
  if (!RESETN_I) begin
    locked_q <= 1'b0;
  end else if (ab_s_q[1]) begin
    locked_q <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////////
// Registered pin outputs; held during power-down
// Lock is checked first so an abort floats pins even while asleep
always @(posedge CLOCK_I or negedge RESETN_I) begin
  if (!RESETN_I) begin
    STATE_O      <= 1'b0;
    IO_PIN_O     <= 1'b0;
    IO_PIN_OE_O  <= 1'b0;
    IO_FAST_O    <= 1'b0;
    TP_PIN_O     <= 4'h0;
    TP_PIN_OE_O  <= 4'h0;
    TP_PIN_IN_O  <= 4'h0;
    POWER_DOWN_O <= 1'b0;
  end else begin
    POWER_DOWN_O <= power_down;
    if (locked_q) begin
      IO_PIN_OE_O <= 1'b0;
      TP_PIN_OE_O <= 4'h0;
    end else if (!power_down) begin
      STATE_O     <= state_q;
      // Polarity bit 1 inverts the buffer, so reset level follows it
      IO_PIN_O    <= state_q ^ outcfg_q[1];
      IO_FAST_O   <= outcfg_q[0];
      // With sleep pin one enabled for power-down, the I/O pin is never driven as logic
      IO_PIN_OE_O <= outcfg_q[2] & ~(cfg_q[`CMR_PDEN_BIT] &
                     cfg_q[`CMR_PD1EN_BIT]);
      if (cfg_q[`CMR_TPDIS_BIT]) begin
        TP_PIN_O    <= outcfg_q[7:4];
        TP_PIN_OE_O <= outcfg_q[11:8];
        TP_PIN_IN_O <= tp_s1_q;
      end else begin
        TP_PIN_OE_O <= 4'h0;
        TP_PIN_IN_O <= 4'h0;
      end
    end
  end
end

endmodule

/* File: dv/cmr_board_model.sv */
`timescale 1ns/1ns
module cmr_board_model (
  input  wire clk_i,
  output reg  net_clk_o,
  output reg  pt_clk_o
);
  // Both clocks idle low, so setup is met before the first high level
  initial begin
    net_clk_o = 1'b0;
    pt_clk_o  = 1'b0;
  end
  // Hold the shared clock net at a level, for latch mode
  task level(input v);
    begin
      @(posedge clk_i);
      net_clk_o <= v;
    end
  endtask
  // One slow pulse; 4 cycles per phase so the 2-flop sampler sees it
  task tick(input sel);
    begin
      @(posedge clk_i);
      if (sel)
        pt_clk_o <= 1'b1;
      else
        net_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      pt_clk_o  <= 1'b0;
      net_clk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
endmodule

/* File: dv/cmr_macrocell_properties.sv */
`timescale 1ns/1ns
`include "cmr_map.vh"
module cmr_macrocell_properties (
  input wire        CLOCK_I,
  input wire        RESETN_I,
  input wire        PSEL_I,
  input wire        PENABLE_I,
  input wire        PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PRDATA_O,
  input wire        PREADY_O,
  input wire        PSLVERR_O,
  input wire        PROG_ABORT_I,
  input wire        STATE_O,
  input wire        IO_PIN_O,
  input wire        IO_PIN_OE_O,
  input wire        IO_FAST_O,
  input wire [3:0]  TP_PIN_OE_O,
  input wire        POWER_DOWN_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  // Setup phase of a transfer
  wire setup = PSEL_I && !PENABLE_I;
  wire rd_s  = setup && !PWRITE_I;
  //////////////////////////////////////////////////////////////////////////
  property p_rdy; setup |=> PREADY_O; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing");
  property p_pls; PREADY_O |=> !PREADY_O; endproperty
  a_pls: assert property (p_pls) else $error("ready too long");
  property p_err;
    setup |=> PSLVERR_O == ($past(PADDR_I) > `CMR_ID_OFF);
  endproperty
  a_err: assert property (p_err) else $error("bad error flag");
  property p_rdz; !PREADY_O |-> PRDATA_O == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read data leak");
  property p_sig;
    rd_s && PADDR_I == `CMR_SIG_OFF |=> PRDATA_O == `CMR_SIG_VAL;
  endproperty
  a_sig: assert property (p_sig) else $error("bad signature");
  property p_id;
    rd_s && PADDR_I == `CMR_ID_OFF |=> PRDATA_O == `CMR_ID_VAL;
  endproperty
  a_id: assert property (p_id) else $error("bad id");
  // Held state must not move while asleep
  property p_frz;
    POWER_DOWN_O && $past(POWER_DOWN_O) |->
      $stable(STATE_O) && $stable(IO_PIN_O) && $stable(IO_FAST_O);
  endproperty
  a_frz: assert property (p_frz) else $error("moved asleep");
  property p_lock;
    $rose(PROG_ABORT_I) |-> ##[1:4] !IO_PIN_OE_O && TP_PIN_OE_O == 4'h0;
  endproperty
  a_lock: assert property (p_lock) else $error("pins driven");
  c_pd: cover property (POWER_DOWN_O);
  c_lock: cover property ($rose(PROG_ABORT_I));
  c_err: cover property (PSLVERR_O);
endmodule

/* File: dv/cmr_macrocell_tb_top.sv */
`timescale 1ns/1ns
`include "cmr_map.vh"
module cmr_macrocell_tb_top;
  reg clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
  reg [11:0] padr = 0;
  reg [31:0] pwd = 0, rdat;
  reg clr_net = 0, xo = 0, dpt = 0, cept = 0, setpt = 0, pin = 0;
  reg s1 = 0, abort = 0, rerr, kpt = 0, cpt = 0, s2 = 0;
  reg [3:0] tpi = 0;
  wire [3:0] tpo, tpoe, tpin;
  wire [31:0] prd;
  wire prdy, perr, ncl, pcl, st, iop, ioe, fast, pd;
  integer miscompares = 0, samples_checked = 0, i;
  always #5 clk = ~clk;
  cmr_board_model brd (.clk_i(clk), .net_clk_o(ncl), .pt_clk_o(pcl));
  cmr_macrocell DUT (.CLOCK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
    .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .SHARED_CLOCK_NET_I(ncl), .SHARED_CLEAR_NET_I(clr_net),
    .XOR_OUT_I(xo), .DATA_PT_I(dpt), .K_PT_I(kpt), .CLOCK_PT_I(pcl),
    .CE_PT_I(cept), .CLEAR_PT_I(cpt), .SET_PT_I(setpt), .IO_PIN_I(pin),
    .SLEEP_PIN_ONE_I(s1), .SLEEP_PIN_TWO_I(s2), .TP_PIN_I(tpi),
    .PROG_ABORT_I(abort), .STATE_O(st), .IO_PIN_O(iop),
    .IO_PIN_OE_O(ioe), .IO_FAST_O(fast), .TP_PIN_O(tpo),
    .TP_PIN_OE_O(tpoe), .TP_PIN_IN_O(tpin), .POWER_DOWN_O(pd));
  //////////////////////////////////////////////////////////////////////////
  task chk(input [63:0] nm, input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("Error %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // One transfer; request held until ready is seen at an edge
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      psel <= 1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1;
      // Look mid-cycle at what will stand at the next rising edge
      @(negedge clk);
      while (prdy !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk);
        @(negedge clk);
      end
      if (n == 20)
        miscompares = miscompares + 1;
      rdat = prd;
      rerr = perr;
      @(posedge clk);
      psel <= 0;
      pen <= 0;
      @(posedge clk);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares = miscompares + 1;
    test_done;
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(0, `CMR_CFG_OFF, 0);
    chk("cfg", rdat, `CMR_CFG_RST);
    chk("fast", fast, 0);
    chk("state", st, 0);
    // Each data source in turn, global clock, D type
    for (i = 0; i < 3; i = i + 1) begin
      apb(1, `CMR_CFG_OFF, 32'h4 + i);
      {pin, dpt, xo} <= 3'h1 << i;
      brd.tick(0);
      chk("dsrc", st, 1);
      {pin, dpt, xo} <= 3'h0;
      brd.tick(0);
      chk("dlow", st, 0);
    end
    apb(1, `CMR_CFG_OFF, 32'h44);
    xo <= 1;
    brd.tick(0);
    chk("ptclk0", st, 0);
    brd.tick(1);
    chk("ptclk1", st, 1);
    apb(1, `CMR_CFG_OFF, 32'h84);
    xo <= 0;
    brd.tick(0);
    chk("ceoff", st, 1);
    cept <= 1;
    brd.tick(0);
    chk("ceon", st, 0);
    apb(1, `CMR_CFG_OFF, 32'h8);
    xo <= 1;
    brd.tick(0);
    chk("tog1", st, 1);
    brd.tick(0);
    chk("tog0", st, 0);
    apb(1, `CMR_CFG_OFF, 32'h10);
    brd.tick(0);
    chk("jkset", st, 1);
    xo <= 0;
    kpt <= 1;
    brd.tick(0);
    chk("jkclr", st, 0);
    xo <= 1;
    brd.tick(0);
    chk("jktog", st, 1);
    apb(1, `CMR_CFG_OFF, 32'h0);
    xo <= 0;
    brd.tick(0);
    chk("srrst", st, 0);
    xo <= 1;
    kpt <= 0;
    brd.tick(0);
    chk("srset", st, 1);
    xo <= 0;
    brd.tick(0);
    chk("srhold", st, 1);
    apb(1, `CMR_CFG_OFF, 32'h24);
    brd.level(1);
    repeat (6) @(posedge clk);
    chk("latlo", st, 0);
    xo <= 1;
    repeat (6) @(posedge clk);
    chk("lathi", st, 1);
    xo <= 0;
    brd.level(0);
    repeat (6) @(posedge clk);
    xo <= 1;
    repeat (6) @(posedge clk);
    chk("lathold", st, 0);
    xo <= 0;
    apb(1, `CMR_CFG_OFF, 32'h504);
    setpt <= 1;
    repeat (8) @(posedge clk);
    chk("set", st, 1);
    clr_net <= 1;
    repeat (8) @(posedge clk);
    chk("clrwin", st, 0);
    apb(1, `CMR_CFG_OFF, 32'h404);
    repeat (8) @(posedge clk);
    chk("clroff", st, 1);
    apb(1, `CMR_CFG_OFF, 32'h604);
    clr_net <= 0;
    cpt <= 1;
    repeat (8) @(posedge clk);
    chk("clrpt", st, 0);
    apb(1, `CMR_CFG_OFF, 32'h704);
    cpt <= 0;
    repeat (8) @(posedge clk);
    chk("orset", st, 1);
    cpt <= 1;
    repeat (8) @(posedge clk);
    chk("clror", st, 0);
    cpt <= 0;
    clr_net <= 0;
    setpt <= 0;
    apb(1, `CMR_CFG_OFF, 32'h1804);
    xo <= 1;
    s1 <= 1;
    repeat (8) @(posedge clk);
    chk("pd", pd, 1);
    brd.tick(0);
    chk("frozen", st, 0);
    s1 <= 0;
    repeat (8) @(posedge clk);
    chk("wake", pd, 0);
    brd.tick(0);
    chk("awake", st, 1);
    apb(1, `CMR_CFG_OFF, 32'h2804);
    s1 <= 1;
    repeat (8) @(posedge clk);
    chk("pd1off", pd, 0);
    s2 <= 1;
    repeat (8) @(posedge clk);
    chk("pd2", pd, 1);
    s1 <= 0;
    s2 <= 0;
    repeat (8) @(posedge clk);
    chk("pd2wake", pd, 0);
    apb(1, `CMR_CFG_OFF, 32'h1804);
    apb(1, `CMR_OUTCFG_OFF, 32'h5);
    repeat (6) @(posedge clk);
    chk("fast", fast, 1);
    chk("pinout", iop, 1);
    chk("sleepoe", ioe, 0);
    apb(1, `CMR_CFG_OFF, 32'h4004);
    apb(0, `CMR_VERIFY_OFF, 0);
    chk("verify", rdat, 0);
    apb(0, `CMR_SIG_OFF, 0);
    chk("sig", rdat, `CMR_SIG_VAL);
    apb(1, `CMR_OUTCFG_OFF, 32'ha55);
    tpi <= 4'h9;
    repeat (6) @(posedge clk);
    chk("tpoff", tpoe, 0);
    chk("oe", ioe, 1);
    apb(1, `CMR_CFG_OFF, 32'hc004);
    repeat (6) @(posedge clk);
    chk("tpo", tpo, 4'h5);
    chk("tpoe", tpoe, 4'ha);
    chk("tpin", tpin, 4'h9);
    apb(0, 12'h018, 0);
    chk("unmap", {rdat[30:0], rerr}, 1);
    abort <= 1;
    repeat (8) @(posedge clk);
    chk("float", ioe, 0);
    chk("tpfloat", tpoe, 0);
    test_done;
  end
endmodule
bind cmr_macrocell cmr_macrocell_properties u_chk (.CLOCK_I(CLOCK_I),
  .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .STATE_O(STATE_O),
  .PROG_ABORT_I(PROG_ABORT_I), .IO_PIN_O(IO_PIN_O),
  .IO_PIN_OE_O(IO_PIN_OE_O), .IO_FAST_O(IO_FAST_O),
  .TP_PIN_OE_O(TP_PIN_OE_O), .POWER_DOWN_O(POWER_DOWN_O));
